// file: dfdac_cfg.svh
// Constants for the dual-frame DAC serial load block.
// Notes on behaviour
// - A falling frame sync arms the shifter for the next 32 falling serial clock edges.
// - Frame sync rising before the 32nd edge aborts and discards the partial word.
// - Low-bank sync addresses channels 0 to 7, high-bank sync channels 8 to 15.
// - A low pulse on the load strobe copies every new input register together.
// - Strobe held low updates automatically; strobe high waits for its next falling edge.
// - Clear falling edge loads input and DAC registers with the clear code value.
// - Clear code picks zero, mid or full scale; it defaults to zero scale.
// - While the clear input is low every load strobe pulse is ignored.
// - The serial input is a 32-bit shifter sampling data on falling clock edges.
// - Serial clock rates up to 50 MHz are accepted; the host stays below.
`ifndef DFDAC_CFG_SVH
`define DFDAC_CFG_SVH

`define DFDAC_FRAME_BITS    32
`define DFDAC_CNT_BITS      6
`define DFDAC_CNT_LAST      6'h1f
`define DFDAC_CNT_ZERO      6'h00
`define DFDAC_CNT_ONE       6'h01
`define DFDAC_SCLK_MAX_MHZ  50

`define DFDAC_CMD_MSB       31
`define DFDAC_CMD_LSB       28
`define DFDAC_CH_MSB        26
`define DFDAC_CH_LSB        24
`define DFDAC_DATA_MSB      15
`define DFDAC_DATA_LSB      0
`define DFDAC_CODE_MSB      1
`define DFDAC_CODE_LSB      0

`define DFDAC_CMD_WRITE     4'h0
`define DFDAC_CMD_CLR_CODE  4'h1

`define DFDAC_DATA_BITS     16
`define DFDAC_ZERO_SCALE    16'h0000
`define DFDAC_MID_SCALE     16'h8000
`define DFDAC_FULL_SCALE    16'hffff
`define DFDAC_BANK_CH       8

`endif

// file: dfdac_pkg.sv
// Types shared by the dual-frame DAC serial load block.
package dfdac_pkg;

  typedef enum logic [1:0]
  {
    DFDAC_CLR_ZERO = 2'h0,
    DFDAC_CLR_MID  = 2'h1,
    DFDAC_CLR_FULL = 2'h2
  } dfdac_clr_code_t;

  typedef struct packed
  {
    logic        bank_high;
    logic [31:0] word;
  } dfdac_frame_t;

endpackage

// file: dfdac_sync.sv
// Two flip-flop level synchroniser for pins entering the core clock domain.
`timescale 1ns/1ps
module dfdac_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk)
  begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;
endmodule // dfdac_sync

// file: dfdac_link_rx.sv
// Serial-clock domain shifter that frames 32-bit words from either sync line.
`timescale 1ns/1ps
`include "dfdac_cfg.svh"
module dfdac_link_rx (
  input  wire logic                  dac_serial_clock,
  input  wire logic                  frame_sync_low_bank,
  input  wire logic                  frame_sync_high_bank,
  input  wire logic                  dac_serial_data_in,
  output dfdac_pkg::dfdac_frame_t    frame_out,
  output logic                       frame_toggle
);
  import dfdac_pkg::*;

  logic [`DFDAC_CNT_BITS-1:0]    count_reg;
  logic [`DFDAC_FRAME_BITS-1:0]  shift_reg;
  logic [`DFDAC_FRAME_BITS-1:0]  shift_next;
  logic                          done_reg;
  dfdac_frame_t                  hold_reg;
  wire                           frame_idle;
  wire                           frame_active;
  wire                           last_edge;

  // The serial clock may stop between frames, so the frame's own end clears the counter.
  assign frame_idle   = frame_sync_low_bank & frame_sync_high_bank;
  assign frame_active = ~frame_idle & ~done_reg;
  assign last_edge    = frame_active & (count_reg == `DFDAC_CNT_LAST);
  assign shift_next   = {shift_reg[`DFDAC_FRAME_BITS-2:0], dac_serial_data_in};

  // An early rising sync resets the count, so the partial word never reaches the hold register.
  always_ff @(negedge dac_serial_clock or posedge frame_idle)
  begin
    if (frame_idle)
    begin
      count_reg <= `DFDAC_CNT_ZERO;
      done_reg  <= 1'b0;
    end
    else if (frame_active)
    begin
      count_reg <= count_reg + `DFDAC_CNT_ONE;
      done_reg  <= last_edge;
    end
  end

  always_ff @(negedge dac_serial_clock)
  begin
    if (frame_active)
    begin
      shift_reg <= shift_next;
    end
  end

  // Hold is rewritten at most once per 32 edges, long after the core has copied it.
  always_ff @(negedge dac_serial_clock)
  begin
    if (last_edge)
    begin
      hold_reg.word      <= shift_next;
      hold_reg.bank_high <= ~frame_sync_high_bank;
    end
  end

  // The done level needs no reset here, since every raised sync clears it; the host must
  // keep the sync low for one core clock after the last edge or the word may be missed.
  assign frame_out    = hold_reg;
  assign frame_toggle = done_reg;
endmodule // dfdac_link_rx

// file: dfdac_top.sv
// Core of the dual-frame DAC serial load block: input, DAC and clear code registers.
`timescale 1ns/1ps
`include "dfdac_cfg.svh"
module dfdac_top #(
  parameter int DATA_BITS = `DFDAC_DATA_BITS,
  parameter int BANK_CH   = `DFDAC_BANK_CH
) (
  input  wire logic                              core_clk,
  input  wire logic                              reset,
  input  wire logic                              dac_serial_clock,
  input  wire logic                              frame_sync_low_bank,
  input  wire logic                              frame_sync_high_bank,
  input  wire logic                              dac_serial_data_in,
  input  wire logic                              load_outputs_strobe,
  input  wire logic                              clear_input,
  output logic [BANK_CH-1:0][DATA_BITS-1:0]      output_channels_low,
  output logic [BANK_CH-1:0][DATA_BITS-1:0]      output_channels_high,
  output dfdac_pkg::dfdac_clr_code_t             clear_code
);
  import dfdac_pkg::*;

  localparam int NCH = 2 * BANK_CH;

  dfdac_frame_t                     link_frame;
  logic                             link_toggle;
  logic [2:0]                       pin_sync;
  logic                             toggle_seen_reg;
  logic                             clear_prev_reg;
  logic [NCH-1:0][DATA_BITS-1:0]    input_reg;
  logic [NCH-1:0][DATA_BITS-1:0]    dac_reg;
  logic [NCH-1:0]                   pending_reg;
  dfdac_clr_code_t                  clr_code_reg;
  wire                              toggle_now;
  wire                              load_low;
  wire                              clear_low;
  wire                              frame_new;
  wire                              clear_fall;
  wire                              update_ok;
  wire  [3:0]                       frame_cmd;
  wire  [2:0]                       frame_ch;
  wire  [DATA_BITS-1:0]             frame_data;
  wire  [1:0]                       frame_code;
  wire                              write_cmd;
  wire                              code_cmd;
  wire  [DATA_BITS-1:0]             clear_value;

  // Maps a clear code to its output value; unknown codes fall back to zero scale.
  function automatic logic [DATA_BITS-1:0] code_value(input dfdac_clr_code_t code);
    logic [DATA_BITS-1:0] v;
    v = DATA_BITS'(`DFDAC_ZERO_SCALE);
    case (code)
      DFDAC_CLR_ZERO: v = DATA_BITS'(`DFDAC_ZERO_SCALE);
      DFDAC_CLR_MID:  v = DATA_BITS'(`DFDAC_MID_SCALE);
      DFDAC_CLR_FULL: v = DATA_BITS'(`DFDAC_FULL_SCALE);
      default:        v = DATA_BITS'(`DFDAC_ZERO_SCALE);
    endcase
    return v;
  endfunction

  // Channel index from bank and in-bank address.
  function automatic int chan_index(input logic bank_high, input logic [2:0] ch);
    return (bank_high ? BANK_CH : 0) + int'(ch);
  endfunction

  dfdac_link_rx u_link (
    .dac_serial_clock     (dac_serial_clock),
    .frame_sync_low_bank  (frame_sync_low_bank),
    .frame_sync_high_bank (frame_sync_high_bank),
    .dac_serial_data_in   (dac_serial_data_in),
    .frame_out            (link_frame),
    .frame_toggle         (link_toggle)
  );

  // Pin levels and the word-done level each cross through two flip-flops.
  dfdac_sync #(.WIDTH(3)) u_sync (
    .clk      (core_clk),
    .async_in ({link_toggle, load_outputs_strobe, clear_input}),
    .sync_out (pin_sync)
  );

  assign toggle_now  = pin_sync[2];
  assign load_low    = ~pin_sync[1];
  assign clear_low   = ~pin_sync[0];
  assign frame_new   = toggle_now & ~toggle_seen_reg;
  assign clear_fall  = clear_prev_reg & clear_low;
  assign update_ok   = load_low & ~clear_low;
  assign frame_cmd   = link_frame.word[`DFDAC_CMD_MSB:`DFDAC_CMD_LSB];
  assign frame_ch    = link_frame.word[`DFDAC_CH_MSB:`DFDAC_CH_LSB];
  assign frame_data  = DATA_BITS'(link_frame.word[`DFDAC_DATA_MSB:`DFDAC_DATA_LSB]);
  assign frame_code  = link_frame.word[`DFDAC_CODE_MSB:`DFDAC_CODE_LSB];
  assign write_cmd   = frame_new & (frame_cmd == `DFDAC_CMD_WRITE);
  assign code_cmd    = frame_new & (frame_cmd == `DFDAC_CMD_CLR_CODE);
  assign clear_value = code_value(clr_code_reg);

  // A synchronous reset follows the current done level so a stale word is not replayed.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      toggle_seen_reg <= toggle_now;
      clear_prev_reg  <= 1'b0;
    end
    else
    begin
      toggle_seen_reg <= toggle_now;
      clear_prev_reg  <= ~clear_low;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      clr_code_reg <= DFDAC_CLR_ZERO;
    end
    else if (code_cmd)
    begin
      clr_code_reg <= dfdac_clr_code_t'(frame_code);
    end
  end

  // Each channel reacts only to words of its own bank; a pulse shorter than one core
  // clock on the strobe may be missed, the price of a plain level synchroniser.
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_chan
      wire hit;
      assign hit = write_cmd & (chan_index(link_frame.bank_high, frame_ch) == g);

      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          input_reg[g]   <= DATA_BITS'(`DFDAC_ZERO_SCALE);
          dac_reg[g]     <= DATA_BITS'(`DFDAC_ZERO_SCALE);
          pending_reg[g] <= 1'b0;
        end
        else if (clear_fall)
        begin
          input_reg[g]   <= clear_value;
          dac_reg[g]     <= clear_value;
          pending_reg[g] <= 1'b0;
        end
        else
        begin
          if (hit)
          begin
            input_reg[g] <= frame_data;
          end
          if (update_ok & pending_reg[g])
          begin
            dac_reg[g] <= input_reg[g];
          end
          // A new word arriving with an update keeps its channel pending.
          pending_reg[g] <= hit | (pending_reg[g] & ~update_ok);
        end
      end
    end
  endgenerate

  assign output_channels_low  = dac_reg[BANK_CH-1:0];
  assign output_channels_high = dac_reg[NCH-1:BANK_CH];
  assign clear_code           = clr_code_reg;
endmodule // dfdac_top

// file: dfdac_host_model.sv
// Host serial master model that frames words onto the link of the DAC block.
`timescale 1ns/1ps
module dfdac_host_model (
  output logic dac_serial_clock,
  output logic frame_sync_low_bank,
  output logic frame_sync_high_bank,
  output logic dac_serial_data_in
);
  // The link side has no reset, so an empty frame at start puts its counter at rest.
  initial
  begin
    dac_serial_clock = 1'b1;
    frame_sync_low_bank = 1'b0;
    frame_sync_high_bank = 1'b0;
    dac_serial_data_in = 1'b0;
    #1;
    frame_sync_low_bank = 1'b1;
    frame_sync_high_bank = 1'b1;
  end

  // The clock idles high between frames, and the released data line is inverted.
  // A count below 32 closes the frame early on purpose.
  task automatic send(input logic high, input logic [31:0] word, input int nbits);
    #3;
    if (high)
      frame_sync_high_bank = 1'b0;
    else
      frame_sync_low_bank = 1'b0;
    for (int i = 31; i > 31 - nbits; i--)
    begin
      dac_serial_data_in = word[i];
      #15 dac_serial_clock = 1'b0;
      #15 dac_serial_clock = 1'b1;
    end
    #15 dac_serial_data_in = ~dac_serial_data_in;
    frame_sync_low_bank = 1'b1;
    frame_sync_high_bank = 1'b1;
    #60;
  endtask
endmodule // dfdac_host_model

// file: dfdac_top_sva.sv
// Assertions on the ports of the dual-frame DAC serial load block.
`timescale 1ns/1ps
module dfdac_top_sva
  import dfdac_pkg::*;
#(
  parameter int DATA_BITS = 16,
  parameter int BANK_CH   = 8
) (
  input wire logic                              core_clk,
  input wire logic                              reset,
  input wire logic                              frame_sync_low_bank,
  input wire logic                              frame_sync_high_bank,
  input wire logic                              load_outputs_strobe,
  input wire logic                              clear_input,
  input wire logic [BANK_CH-1:0][DATA_BITS-1:0] output_channels_low,
  input wire logic [BANK_CH-1:0][DATA_BITS-1:0] output_channels_high,
  input wire dfdac_pkg::dfdac_clr_code_t        clear_code
);
  logic [DATA_BITS-1:0]           clr_val;
  logic [2*BANK_CH*DATA_BITS-1:0] outs;
  assign clr_val = (clear_code == DFDAC_CLR_MID) ? 16'h8000 :
                   (clear_code == DFDAC_CLR_FULL) ? 16'hffff : 16'h0000;
  assign outs = {output_channels_high, output_channels_low};

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  // Margins cover the two-stage pin synchronisers plus one register stage.
  sequence s_clear_entry;
    $fell(clear_input) ##1 !clear_input [*4];
  endsequence
  sequence s_quiet_link;
    (frame_sync_low_bank && frame_sync_high_bank) [*8];
  endsequence

  chk_clear_loads_code: assert property (s_clear_entry |-> outs == {2*BANK_CH{clr_val}})
    else $error("outputs not at clear value");
  chk_frozen_in_clear: assert property (!clear_input [*6] |-> $stable(outs))
    else $error("outputs moved while clear low");
  chk_wait_for_strobe: assert property ((load_outputs_strobe && clear_input) [*7] |-> $stable(outs))
    else $error("outputs moved with strobe high");
  chk_auto_needs_word: assert property ((s_quiet_link and (!load_outputs_strobe && clear_input) [*8])
    |-> $stable(outs))
    else $error("outputs moved without a word");
  chk_code_needs_frame: assert property (s_quiet_link |-> $stable(clear_code))
    else $error("clear code moved without a frame");
  chk_code_legal: assert property (clear_code inside {DFDAC_CLR_ZERO, DFDAC_CLR_MID, DFDAC_CLR_FULL})
    else $error("clear code out of range");
  chk_reset_zero: assert property (disable iff (1'b0) reset |=> outs == '0 && clear_code == DFDAC_CLR_ZERO)
    else $error("reset did not zero outputs");
  chk_bank_low_idle: assert property ((frame_sync_low_bank && clear_input && $stable(load_outputs_strobe)) [*8]
    |-> $stable(output_channels_low))
    else $error("low bank moved without its frame");
endmodule // dfdac_top_sva

bind dfdac_top dfdac_top_sva #(.DATA_BITS(DATA_BITS), .BANK_CH(BANK_CH)) chk_u (.core_clk, .reset,
  .frame_sync_low_bank, .frame_sync_high_bank, .load_outputs_strobe, .clear_input,
  .output_channels_low, .output_channels_high, .clear_code);

// file: dfdac_top_bench.sv
// Self-checking bench for the dual-frame DAC serial load block.
`timescale 1ns/1ps
module dfdac_top_bench;
  import dfdac_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  reset = 1'b1;
  logic                  load_outputs_strobe = 1'b1;
  logic                  clear_input = 1'b1;
  logic                  dac_serial_clock;
  logic                  frame_sync_low_bank;
  logic                  frame_sync_high_bank;
  logic                  dac_serial_data_in;
  logic [7:0][15:0]      out_low;
  logic [7:0][15:0]      out_high;
  dfdac_clr_code_t       code;
  int                    n_mismatch = 0;
  int                    compares = 0;
  int                    cycles = 0;

  dfdac_host_model host_u (.dac_serial_clock, .frame_sync_low_bank, .frame_sync_high_bank,
    .dac_serial_data_in);
  dfdac_top dut_u (.core_clk, .reset, .dac_serial_clock, .frame_sync_low_bank,
    .frame_sync_high_bank, .dac_serial_data_in, .load_outputs_strobe, .clear_input,
    .output_channels_low(out_low), .output_channels_high(out_high), .clear_code(code));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ten core clocks exceed the worst synchroniser and update latency.
  task automatic settle();
    repeat (10) @(negedge core_clk);
  endtask

  task automatic set_strobe(input logic v);
    @(negedge core_clk);
    load_outputs_strobe = v;
  endtask

  function automatic logic [31:0] wr(input logic [2:0] ch, input logic [15:0] val);
    return {4'h0, 1'b0, ch, 8'h00, val};
  endfunction

  task automatic t_auto();
    set_strobe(1'b0);
    host_u.send(1'b0, wr(3'h3, 16'h1234), 32);
    host_u.send(1'b1, wr(3'h7, 16'habcd), 32);
    settle();
    check(out_low[3], 16'h1234);
    check(out_high[7], 16'habcd);
    check(out_high[3], 16'h0000);
    check(out_low[7], 16'h0000);
  endtask

  task automatic t_strobe();
    set_strobe(1'b1);
    host_u.send(1'b0, wr(3'h0, 16'h5a5a), 32);
    host_u.send(1'b1, wr(3'h1, 16'h0f0f), 32);
    settle();
    check(out_low[0], 16'h0000);
    set_strobe(1'b0);
    settle();
    check(out_low[0], 16'h5a5a);
    check(out_high[1], 16'h0f0f);
  endtask

  task automatic t_abort();
    host_u.send(1'b0, wr(3'h3, 16'hffff), 31);
    settle();
    check(out_low[3], 16'h1234);
    host_u.send(1'b0, wr(3'h5, 16'h2468), 32);
    settle();
    check(out_low[3], 16'h1234);
    check(out_low[5], 16'h2468);
  endtask

  task automatic t_clear();
    logic [15:0] vals [3] = '{16'h0000, 16'h8000, 16'hffff};
    for (int c = 2; c >= 0; c--)
    begin
      host_u.send(1'b0, {4'h1, 26'h0, c[1:0]}, 32);
      settle();
      check({14'h0, code}, {14'h0, c[1:0]});
      @(negedge core_clk);
      clear_input = 1'b0;
      settle();
      check(out_low[3], vals[c]);
      check(out_high[7], vals[c]);
      host_u.send(1'b1, wr(3'h7, 16'h4321), 32);
      set_strobe(1'b1);
      settle();
      set_strobe(1'b0);
      settle();
      check(out_high[7], vals[c]);
      @(negedge core_clk);
      clear_input = 1'b1;
      settle();
    end
  endtask

  initial
  begin
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    check({14'h0, code}, 16'h0000);
    check(out_low[0], 16'h0000);
    t_auto();
    t_strobe();
    t_abort();
    t_clear();
    give_verdict();
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
endmodule // dfdac_top_bench
